// ---- hw/trap_pkg.sv ----
// Constants, vectors, register map and carrier types for the trap and stack check unit.
package trap_pkg;

  // Number of arbitrated request sources, in priority order.
  localparam int unsigned NUM_SRC = 17;

  // Source positions in the request vector; position 0 wins.
  localparam int unsigned SRC_CONSOLE = 0;
  localparam int unsigned SRC_MMGT    = 1;
  localparam int unsigned SRC_YELLOW  = 2;
  localparam int unsigned SRC_POWER_FAIL_TRAP    = 3;
  localparam int unsigned SRC_FLOAT   = 4;
  localparam int unsigned SRC_TRACE   = 16;

  // Interrupt level of each source; zero means the priority field never blocks it.
  localparam logic [2:0] SRC_LEVEL [NUM_SRC] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h6, 3'h6,
    3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  // Sources that are external bus requests rather than internal traps.
  localparam logic [NUM_SRC-1:0] SRC_IS_BUS = 17'h0_1540;

  // Trap vectors, octal values as used by the processor.
  localparam logic [8:0] VEC_FLOAT  = 9'o244;
  localparam logic [8:0] VEC_MMGT   = 9'o250;
  localparam logic [8:0] VEC_POWER_FAIL_TRAP   = 9'o024;
  localparam logic [8:0] VEC_TRACE  = 9'o014;
  localparam logic [8:0] VEC_PROGRAM_INTERRUPT_REQUEST   = 9'o240;
  localparam logic [8:0] VEC_YELLOW = 9'o004;
  localparam logic [8:0] VEC_NONE   = 9'h0_000;

  // Break branch codes and their microaddresses.
  localparam logic [1:0] BRK_POWER_UP = 2'b00;
  localparam logic [1:0] BRK_NO_TRAP  = 2'b01;
  localparam logic [1:0] BRK_TRAP     = 2'b10;
  localparam logic [1:0] BRK_STACK    = 2'b11;
  localparam logic [7:0] UADDR_POWER_UP = 8'o100;
  localparam logic [7:0] UADDR_NO_TRAP  = 8'o120;
  localparam logic [7:0] UADDR_TRAP     = 8'o140;
  localparam logic [7:0] UADDR_STACK    = 8'o160;

  // Address bits 7 to 5 all ones mark the 16-word warning zone.
  localparam logic [2:0] WARN_ZONE_BITS = 3'h7;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_CONTROL     = 8'h00;
  localparam logic [7:0] REG_STACK_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS      = 8'h08;
  localparam logic [7:0] REG_HONOR       = 8'h0C;

  // Control register fields and reset values.
  localparam int unsigned CTRL_PRIO_LSB   = 0;
  localparam int unsigned CTRL_LEGACY_BIT = 3;
  localparam logic [2:0]  PRIO_RESET      = 3'h0;
  localparam logic [7:0]  LIMIT_RESET     = 8'h00;

  // Bus transfer type for a new single transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // Request lines from the processor, all active high.
  typedef struct packed {
    logic       console_flag;
    logic       memory_mgmt_trap;
    logic       power_fail_trap;
    logic       float_exception_trap;
    logic       trace_trap;
    logic [7:1] program_interrupt_request;
    logic [7:4] bus_request;
  } request_t;

  // Description of the current bus cycle from the microsequencer.
  typedef struct packed {
    logic [15:0] bus_address_mux;
    logic        byte_instruction;
    logic        first_byte_operand_cycle;
    logic        second_byte_operand_cycle;
    logic        first_source_read;
    logic        second_source_read;
    logic        kernel_stack_reference;
    logic        stack_write_or_pause;
    logic        internal_address_hit;
  } cycle_t;

endpackage

// ---- hw/trap_priority_stack_check.sv ----
// Trap arbitration, break branch selection, odd address and stack limit checking.
`timescale 1ns/10ps

// Overview of operation
// [RQ1] Honor a request only when no higher priority request is pending.
// [RQ2] Priority field blocks interrupt levels at and below its value.
// [RQ3] Pending-service asserted whenever any honor output is active.
// [RQ4] Vector enable set on interrupt pause entry unless servicing a bus request.
// [RQ5] With vector enable set, honored trap drives its fixed vector.
// [RQ6] Trap inhibit asserted while vector enable or request-strobe block set.
// [RQ7] Vector enable cleared by the bus acknowledge after vector load.
// [RQ8] Break select: power-up 00, no trap 01, trap 10, stack error 11.
// [RQ9] Break targets are microaddresses 100, 120, 140 and 160.
// [RQ10] Odd address during a non-byte instruction is an odd-address error.
// [RQ11] Plain, kernel, conditional and write cycles fault on odd address always.
// [RQ12] Odd address legal only in byte operand, second or non-legacy first source reads.
// [RQ13] Kernel stack cycles compare address high byte with limit; below is red.
// [RQ14] Fatal violation set at T5 only while error flag or strobe block clear.
// [RQ15] Fatal violation held until abort acknowledge.
// [RQ16] Equal high byte outside the warning zone is fatal at T5.
// [RQ17] Stack reference to an internal register address is fatal.
// [RQ18] Equal high byte inside warning zone sets warning flag at T2.
// [RQ19] Warning sets stack error flag only when honored and acknowledged.
// [RQ20] All flags cleared by initialization and sampled on the clock.
module trap_priority_stack_check
  import trap_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Bus slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Requests and processor state
  input  wire request_t         requests,
  input  wire logic             power_up_flag,
  input  wire logic             t2_pulse,
  input  wire logic             t5_pulse,
  input  wire logic             interrupt_pause_state,
  input  wire logic             bus_acknowledge,
  input  wire logic             abort_acknowledge,
  input  wire logic             abort_clear,
  input  wire logic             clear_flags,
  // Current bus cycle
  input  wire cycle_t           cycle,
  // Results to the microsequencer
  output logic                  service_request_pending,
  output logic [NUM_SRC-1:0]    honor,
  output logic                  internal_trap_pending,
  output logic                  vector_enable_flag,
  output logic [8:0]            trap_vector,
  output logic                  trap_vector_inhibit,
  output logic [1:0]            break_branch_select,
  output logic [7:0]            break_target,
  output logic                  odd_address_error,
  output logic                  fatal_stack_violation,
  output logic                  stack_warning_flag,
  output logic                  stack_error_flag,
  output logic                  request_strobe_block
);

  logic [2:0]         processor_priority;
  logic               legacy_model_option;
  logic [7:0]         stack_limit_register;
  logic [7:1]         block_level;
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] next_honor;
  logic               next_trap;
  logic [8:0]         next_vector;
  logic               stack_check;
  logic               high_equal;
  logic               high_below;
  logic               warning_zone_match;
  logic               red_condition;
  logic               odd_legal;
  logic [1:0]         next_select;
  logic [7:0]         next_target;
  logic               bus_write;
  logic               bus_read;
  logic [31:0]        read_value;
  logic               honor_bus;

  // Level blocks.
  // [RQ2] Decode priority field.
  genvar lv;
  generate
    for (lv = 1; lv <= 7; lv++)
    begin : g_block
      assign block_level[lv] = (processor_priority >= 3'(lv));
    end
  endgenerate

  assign raw_req = {requests.trace_trap,
                    requests.program_interrupt_request[1],
                    requests.program_interrupt_request[2],
                    requests.program_interrupt_request[3],
                    requests.bus_request[4],
                    requests.program_interrupt_request[4],
                    requests.bus_request[5],
                    requests.program_interrupt_request[5],
                    requests.bus_request[6],
                    requests.program_interrupt_request[6],
                    requests.bus_request[7],
                    requests.program_interrupt_request[7],
                    requests.float_exception_trap,
                    requests.power_fail_trap,
                    stack_warning_flag,
                    requests.memory_mgmt_trap,
                    requests.console_flag};

  // Mask each source by its level.
  genvar si;
  generate
    for (si = 0; si < NUM_SRC; si++)
    begin : g_mask
      // [RQ2] Level gating; level zero is never blocked.
      if (SRC_LEVEL[si] == 3'h0)
        assign eligible[si] = raw_req[si];
      else
        assign eligible[si] = raw_req[si] && !block_level[SRC_LEVEL[si]];
    end
  endgenerate

  // [RQ1] Fixed priority pick.
  always_comb
  begin
    next_honor = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        next_honor = '0;
        next_honor[i] = 1'b1;
      end
    end
  end

  assign next_trap = |(next_honor & ~SRC_IS_BUS & ~(NUM_SRC'(1) << SRC_CONSOLE));
  assign honor_bus = |(honor & SRC_IS_BUS);

  // A strobe block during an abort keeps every honor output low.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      honor                   <= '0;
      service_request_pending <= 1'b0;
      internal_trap_pending   <= 1'b0;
    end
    else
    begin
      // [RQ1] Register the winner.
      honor                   <= request_strobe_block ? '0 : next_honor;
      // [RQ3] Any honor pending.
      service_request_pending <= !request_strobe_block && (|next_honor);
      internal_trap_pending   <= !request_strobe_block && next_trap;
    end
  end

  // Vector enable.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vector_enable_flag <= 1'b0;
    end
    else if (interrupt_pause_state && !honor_bus)
    begin
      // [RQ4] Set unless bus request.
      vector_enable_flag <= 1'b1;
    end
    else if (bus_acknowledge)
    begin
      // [RQ7] Cleared by acknowledge.
      vector_enable_flag <= 1'b0;
    end
  end

  // [RQ5] Vector per trap.
  always_comb
  begin
    next_vector = VEC_NONE;
    if (vector_enable_flag)
    begin
      if (honor[SRC_FLOAT])
        next_vector = VEC_FLOAT;
      else if (honor[SRC_MMGT])
        next_vector = VEC_MMGT;
      else if (honor[SRC_POWER_FAIL_TRAP])
        next_vector = VEC_POWER_FAIL_TRAP;
      else if (honor[SRC_YELLOW])
        next_vector = VEC_YELLOW;
      else if (honor[SRC_TRACE])
        next_vector = VEC_TRACE;
      else if (|(honor & ~SRC_IS_BUS & ~(NUM_SRC'(1) << SRC_CONSOLE)))
        next_vector = VEC_PROGRAM_INTERRUPT_REQUEST;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trap_vector         <= VEC_NONE;
      trap_vector_inhibit <= 1'b0;
    end
    else
    begin
      trap_vector         <= next_vector;
      // [RQ6] Inhibit instruction vectors.
      trap_vector_inhibit <= vector_enable_flag || request_strobe_block;
    end
  end

  // An abort blocks strobing; stack aborts hold it until the next fetch, power aborts only until the bus acknowledge as the block clears honor.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      request_strobe_block <= 1'b0;
    else if (abort_clear)
      request_strobe_block <= 1'b1;
    else if (clear_flags)
      request_strobe_block <= 1'b0;
    else if (bus_acknowledge && !stack_error_flag && !honor[SRC_POWER_FAIL_TRAP])
      request_strobe_block <= 1'b0;
  end

  // [RQ8] Break select encoding.
  always_comb
  begin
    if (stack_error_flag)
      next_select = BRK_STACK;
    else if (power_up_flag)
      next_select = BRK_POWER_UP;
    else if (next_trap && !request_strobe_block)
      next_select = BRK_TRAP;
    else
      next_select = BRK_NO_TRAP;
    // [RQ9] Microaddress map.
    case (next_select)
      BRK_POWER_UP: next_target = UADDR_POWER_UP;
      BRK_NO_TRAP:  next_target = UADDR_NO_TRAP;
      BRK_TRAP:     next_target = UADDR_TRAP;
      default:      next_target = UADDR_STACK;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      break_branch_select <= BRK_POWER_UP;
      break_target        <= UADDR_POWER_UP;
    end
    else
    begin
      break_branch_select <= next_select;
      break_target        <= next_target;
    end
  end

  // [RQ12] Legal odd-address cycles.
  assign odd_legal = cycle.first_byte_operand_cycle || cycle.second_byte_operand_cycle ||
                     cycle.second_source_read ||
                     (cycle.first_source_read && !legacy_model_option);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      odd_address_error <= 1'b0;
    else
      // [RQ10] [RQ11] Odd address check.
      odd_address_error <= cycle.bus_address_mux[0] &&
                           (!cycle.byte_instruction || !odd_legal);
  end

  // [RQ13] Stack limit compare.
  assign stack_check        = cycle.kernel_stack_reference && cycle.stack_write_or_pause;
  assign high_equal         = cycle.bus_address_mux[15:8] == stack_limit_register;
  assign high_below         = cycle.bus_address_mux[15:8] < stack_limit_register;
  assign warning_zone_match = cycle.bus_address_mux[7:5] == WARN_ZONE_BITS;
  // [RQ16] [RQ17] Red conditions.
  assign red_condition = stack_check &&
                         (high_below || (high_equal && !warning_zone_match) ||
                          cycle.internal_address_hit);

  // The latch must outlive the pause so the abort routine sees it.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      fatal_stack_violation <= 1'b0;
    // [RQ14] Set at T5 when unblocked.
    else if (t5_pulse && red_condition && (!stack_error_flag || !request_strobe_block))
      fatal_stack_violation <= 1'b1;
    // [RQ15] Held until acknowledge.
    else if (abort_acknowledge)
      fatal_stack_violation <= 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      stack_warning_flag <= 1'b0;
    // [RQ18] Warning at T2.
    else if (t2_pulse && stack_check && high_equal && warning_zone_match)
      stack_warning_flag <= 1'b1;
    else if (bus_acknowledge && honor[SRC_YELLOW])
      stack_warning_flag <= 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      stack_error_flag <= 1'b0;
    else if (t2_pulse && fatal_stack_violation)
      stack_error_flag <= 1'b1;
    // [RQ19] Deferred warning service.
    else if (bus_acknowledge && honor[SRC_YELLOW])
      stack_error_flag <= 1'b1;
    // [RQ20] Cleared at next fetch.
    else if (clear_flags)
      stack_error_flag <= 1'b0;
  end

  // Zero wait state slave; read data is captured in the address phase.
  assign bus_write = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  assign bus_read  = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;

  logic       wr_pending;
  logic [7:0] wr_offset;

  always_comb
  begin
    case (haddr[7:0])
      REG_CONTROL:     read_value = {28'h000_0000, legacy_model_option, processor_priority};
      REG_STACK_LIMIT: read_value = {24'h00_0000, stack_limit_register};
      REG_STATUS:      read_value = {18'h0_0000, break_branch_select, request_strobe_block,
                                     stack_error_flag, stack_warning_flag,
                                     fatal_stack_violation, odd_address_error,
                                     trap_vector_inhibit, vector_enable_flag,
                                     internal_trap_pending, service_request_pending,
                                     power_up_flag, 2'b00};
      REG_HONOR:       read_value = {15'h0000, honor};
      default:         read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= 1'b0;
      wr_offset  <= 8'h00;
    end
    else
    begin
      hrdata     <= bus_read ? read_value : 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= bus_write;
      wr_offset  <= haddr[7:0];
    end
  end

  // Software writes the priority field, option and stack limit in the data phase.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      processor_priority   <= PRIO_RESET;
      legacy_model_option  <= 1'b0;
      stack_limit_register <= LIMIT_RESET;
    end
    else if (wr_pending && wr_offset == REG_CONTROL)
    begin
      processor_priority  <= hwdata[CTRL_PRIO_LSB +: 3];
      legacy_model_option <= hwdata[CTRL_LEGACY_BIT];
    end
    else if (wr_pending && wr_offset == REG_STACK_LIMIT)
    begin
      stack_limit_register <= hwdata[7:0];
    end
  end

endmodule // trap_priority_stack_check

// ---- test/trap_sequencer_model.sv ----
// Behavioural model of the microsequencer timing pulses and bus acknowledge.
`timescale 1ns/10ps
module trap_sequencer_model #(parameter int ACK_DELAY = 6)
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Pause entry
  input  wire logic interrupt_pause_state,
  // Timing and acknowledge
  output logic      t2_pulse,
  output logic      t5_pulse,
  output logic      bus_acknowledge
);
  logic [2:0] time_state;
  logic [3:0] ack_count;
  // Six time states repeat without gaps, so each stack check sees at least one T2 and one T5.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      time_state <= 3'h0;
      t2_pulse   <= 1'b0;
      t5_pulse   <= 1'b0;
    end
    else
    begin
      time_state <= (time_state == 3'h5) ? 3'h0 : time_state + 3'h1;
      t2_pulse   <= (time_state == 3'h0);
      t5_pulse   <= (time_state == 3'h3);
    end
  end
  // Late acknowledge, so the vector is seen first.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_count       <= 4'h0;
      bus_acknowledge <= 1'b0;
    end
    else
    begin
      ack_count       <= interrupt_pause_state ? 4'(ACK_DELAY) :
                         (ack_count != 4'h0) ? ack_count - 4'h1 : 4'h0;
      bus_acknowledge <= (ack_count == 4'h1);
    end
  end
endmodule // trap_sequencer_model

// ---- test/trap_check_properties.sv ----
// Port-level assertions for the trap and stack check unit.
`timescale 1ns/10ps
module trap_check_properties
  import trap_pkg::*;
(
  // Clock and reset
  input wire logic               mclk,
  input wire logic               reset_n,
  // Processor side
  input wire logic               interrupt_pause_state,
  input wire logic               bus_acknowledge,
  input wire logic               abort_acknowledge,
  input wire logic               t5_pulse,
  input wire cycle_t             cycle,
  // Results
  input wire logic               service_request_pending,
  input wire logic [NUM_SRC-1:0] honor,
  input wire logic               vector_enable_flag,
  input wire logic [8:0]         trap_vector,
  input wire logic               trap_vector_inhibit,
  input wire logic [1:0]         break_branch_select,
  input wire logic [7:0]         break_target,
  input wire logic               odd_address_error,
  input wire logic               fatal_stack_violation,
  input wire logic               stack_error_flag,
  input wire logic               request_strobe_block
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence pause_no_bus;
    interrupt_pause_state && service_request_pending && (honor & SRC_IS_BUS) == '0;
  endsequence
  sequence float_vec_on;
    vector_enable_flag && honor[SRC_FLOAT];
  endsequence
  sequence red_internal;
    t5_pulse && cycle.kernel_stack_reference && cycle.stack_write_or_pause &&
      cycle.internal_address_hit && !(stack_error_flag && request_strobe_block);
  endsequence
  one_winner_a: assert property ($onehot0(honor))
    else $error("several requests honored");
  service_pend_a: assert property (service_request_pending == (|honor))
    else $error("service pending wrong");
  vec_set_a: assert property (pause_no_bus |=> vector_enable_flag)
    else $error("vector enable not set on pause");
  float_vec_a: assert property (float_vec_on |=> trap_vector == 9'o244)
    else $error("wrong float vector");
  vec_inhibit_a: assert property (vector_enable_flag |=> trap_vector_inhibit)
    else $error("inhibit missing");
  block_refuse_a: assert property (request_strobe_block [*2] |-> honor == '0)
    else $error("honored while blocked");
  vec_clear_a: assert property (vector_enable_flag && bus_acknowledge &&
    !interrupt_pause_state |=> !vector_enable_flag) else $error("vector enable not cleared");
  target_map_a: assert property (break_target == (
    break_branch_select == BRK_POWER_UP ? 8'o100 : break_branch_select == BRK_NO_TRAP ? 8'o120 :
    break_branch_select == BRK_TRAP ? 8'o140 : 8'o160)) else $error("wrong break target");
  odd_err_a: assert property (cycle.bus_address_mux[0] && !cycle.byte_instruction
    |=> odd_address_error) else $error("odd address missed");
  internal_red_a: assert property (red_internal |=> fatal_stack_violation)
    else $error("internal red missed");
  fatal_hold_a: assert property (fatal_stack_violation && !abort_acknowledge
    |=> fatal_stack_violation) else $error("fatal violation dropped early");
endmodule // trap_check_properties

bind trap_priority_stack_check trap_check_properties chk_i (.*);

// ---- test/tb_trap_priority_stack_check.sv ----
// Self-checking bench for the trap and stack check unit.
`timescale 1ns/10ps
module tb_trap_priority_stack_check
  import trap_pkg::*;
;
  logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp, power_up_flag, t2_pulse;
  logic        t5_pulse, bus_acknowledge, service_request_pending, internal_trap_pending;
  logic        vector_enable_flag, trap_vector_inhibit, odd_address_error, trap;
  logic        fatal_stack_violation, stack_warning_flag, stack_error_flag, request_strobe_block;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, break_branch_select;
  logic [2:0]  hsize;
  logic [3:0]  strobes;
  logic [16:0] honor;
  logic [8:0]  trap_vector;
  logic [7:0]  break_target;
  request_t    requests;
  cycle_t      cycle;
  int          n_fail, checks_done;
  localparam logic [31:0] CTRL = 32'(REG_CONTROL);
  localparam logic [15:0] ARB_REQ [8] = '{16'h0800, 16'h6000, 16'h0106, 16'h0106, 16'h0112,
    16'h0112, 16'h1408, 16'h7FFF};
  localparam logic [2:0]  ARB_PRI [8] = '{3'h0, 3'h0, 3'h5, 3'h6, 3'h5, 3'h4, 3'h7, 3'h0};
  localparam logic [16:0] ARB_HON [8] = '{17'h1_0000, 17'h0_0002, 17'h0_0100, 17'h0_0000,
    17'h0_0000, 17'h0_0200, 17'h0_0010, 17'h0_0002};
  localparam logic [15:0] VEC_REQ [5] = '{16'h1000, 16'h4000, 16'h2000, 16'h0800, 16'h0040};
  localparam logic [8:0]  VEC_EXP [5] = '{9'o244, 9'o250, 9'o024, 9'o014, 9'o240};
  localparam logic [7:0]  ODD_F [7] = '{8'h00, 8'h80, 8'hC0, 8'hA0, 8'h88, 8'h90, 8'h90};
  localparam logic [15:0] STK_A [6] = '{16'h3F00, 16'h4000, 16'h8000, 16'h3F00, 16'h4100,
    16'h40E0};
  localparam logic [7:0]  STK_F [6] = '{8'h06, 8'h06, 8'h07, 8'h02, 8'h06, 8'h06};

  trap_priority_stack_check uut (.*, .hready(hreadyout), .interrupt_pause_state(strobes[0]),
    .abort_acknowledge(strobes[1]), .abort_clear(strobes[2]), .clear_flags(strobes[3]));
  trap_sequencer_model seq (.*, .interrupt_pause_state(strobes[0]));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Address phase held until hready is high, then the data phase.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  task automatic drive(input logic [15:0] r, input logic [15:0] a, input logic [7:0] f);
    @(posedge mclk);
    requests <= r;
    cycle    <= {a, f};
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge mclk);
    strobes <= p;
    @(posedge mclk);
    strobes <= 4'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // A healthy run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    wrap_up;
  end
  initial
  begin
    {reset_n, hsel, hwrite, power_up_flag, haddr, hwdata, htrans, strobes} = '0;
    {requests, cycle} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd("control", CTRL, 32'h0);
    rd("limit", 32'(REG_STACK_LIMIT), 32'h0);
    rd("status", 32'(REG_STATUS), 32'h1000);
    rd("honor_reg", 32'(REG_HONOR), 32'h0);
    rd("unmapped", 32'h10, 32'h0);
    $display("register test done");
    foreach (ARB_REQ[i])
    begin
      wr(CTRL, 32'(ARB_PRI[i]));
      drive(ARB_REQ[i], 16'h0000, 8'h00);
      settle(2);
      trap = (ARB_HON[i] & ~SRC_IS_BUS) != '0;
      chk("honor", 32'(ARB_HON[i]), 32'(honor));
      chk("service", 32'(ARB_HON[i] != '0), 32'(service_request_pending));
      chk("trap", 32'(trap), 32'(internal_trap_pending));
      chk("select", 32'(trap ? 2'b10 : 2'b01), 32'(break_branch_select));
      chk("target", 32'(trap ? 8'o140 : 8'o120), 32'(break_target));
    end
    $display("arbitration test done");
    wr(CTRL, 32'h0);
    foreach (VEC_REQ[i])
    begin
      drive(VEC_REQ[i], 16'h0000, 8'h00);
      settle(2);
      pulse(4'h1);
      settle(2);
      chk("vec_en", 32'h1, 32'(vector_enable_flag));
      chk("vector", 32'(VEC_EXP[i]), 32'(trap_vector));
      chk("inhibit", 32'h1, 32'(trap_vector_inhibit));
      settle(8);
      chk("vec_clr", 32'h0, 32'(vector_enable_flag));
    end
    drive(16'h0008, 16'h0000, 8'h00);
    settle(2);
    pulse(4'h1);
    settle(2);
    chk("vec_bus", 32'h0, 32'(vector_enable_flag));
    settle(6);
    drive(16'h0800, 16'h0000, 8'h00);
    pulse(4'h4);
    settle(3);
    chk("blocked", 32'h1, 32'(trap_vector_inhibit));
    chk("blk_flag", 32'h1, 32'(request_strobe_block));
    chk("blk_honor", 32'h0, 32'(honor));
    pulse(4'h8);
    settle(3);
    chk("unblocked", 32'h1_0000, 32'(honor));
    $display("vector test done");
    foreach (ODD_F[i])
    begin
      wr(CTRL, (i == 6) ? 32'h8 : 32'h0);
      drive(16'h0000, 16'h1001, ODD_F[i]);
      settle(2);
      chk("odd", 32'(i < 2 || i == 6), 32'(odd_address_error));
    end
    $display("odd address test done");
    wr(32'(REG_STACK_LIMIT), 32'h0000_0040);
    foreach (STK_A[i])
    begin
      drive(16'h0000, STK_A[i], STK_F[i]);
      settle(8);
      drive(16'h0000, 16'h0000, 8'h00);
      settle(3);
      chk("fatal", 32'(i < 3), 32'(fatal_stack_violation));
      chk("warn", 32'(i == 5), 32'(stack_warning_flag));
      pulse(4'hA);
      settle(2);
      chk("fatal_clr", 32'h0, 32'(fatal_stack_violation));
    end
    chk("stack_error_flag_wait", 32'h0, 32'(stack_error_flag));
    chk("warn_honor", 32'h4, 32'(honor));
    pulse(4'h1);
    settle(10);
    chk("stack_error_flag_set", 32'h1, 32'(stack_error_flag));
    chk("stk_select", 32'h3, 32'(break_branch_select));
    chk("stk_target", 32'(8'o160), 32'(break_target));
    @(posedge mclk);
    power_up_flag <= 1'b1;
    settle(2);
    chk("pup_stack_error_flag", 32'h3, 32'(break_branch_select));
    pulse(4'h8);
    settle(2);
    chk("pup_select", 32'h0, 32'(break_branch_select));
    chk("pup_target", 32'(8'o100), 32'(break_target));
    $display("stack test done");
    wrap_up;
  end
endmodule // tb_trap_priority_stack_check
